// ===== design/bop_map.svh
// Constants for the bus octet protocol slave block.
// What this block does
// - Port B wins per hold/select contention table.
// - Unknown bus control ends transfer without data.
// - Bus acknowledge octet zero, good parity, stable.
// - Slave status bit 7 reports prior success.
// - Slave status bit 6 reports detected parity error.
// - Request bit 7 clear means broadcast poll.
// - Poll bits 6,5,3 ask busy, ready, powered.
// - Power fail acknowledged after graceful shutdown done.
// - Poll bits 2,1,0 ask interrupt classes 3,2,1.
// - Several requested conditions answer as logical OR.
// - Addressed slave decodes facility interrupt request.
// - Bit 3 picks facility group low or high.
// - Zero bits 0-3 return transfer settings octet.
// - Bit 3 alone returns slave interrupts octet.
// - Reset control bits 0-3 used in reset phases.
// - Poll answer drives own bit only, no control.
// - Facility answer bit n maps facility n or n+8.
// - No response bus answer during selective reset.
// - Parity line released on one-hot address answers.
// - Selection bit 1 hold, bit 0 preempt select.
`ifndef BOP_MAP_SVH
`define BOP_MAP_SVH
`define BOP_SEL_HOLD_BIT 1
`define BOP_SEL_PREEMPT_BIT 0
`define BOP_STAT_OK_BIT 7
`define BOP_STAT_PERR_BIT 6
`define BOP_RQ_ADDRESSED_BIT 7
`define BOP_RQ_BUSY_BIT 6
`define BOP_RQ_READY_BIT 5
`define BOP_RQ_PWRFAIL_BIT 4
`define BOP_RQ_PWRON_BIT 3
`define BOP_RQ_RANGE_BIT 3
`define BOP_RQ_ADDR_LSB 4
`define BOP_RQ_ADDR_MSB 6
`define BOP_RQ_CLASS_MSB 2
`define BOP_RQ_LOW_MSB 3
`define BOP_RST_TYPE_MSB 3
`define BOP_OCTET_ZERO 8'h00
`define BOP_NIBBLE_ZERO 4'h0
`define BOP_CLASS_ZERO 3'h0
`endif

// ===== design/bop_pkg.sv
// Types for the bus octet protocol slave block.
package bop_pkg;
	// Protocol state seen by the slave on the control lines.
	typedef enum logic [7:0] {
		BOP_IDLE = 8'h01,
		BOP_SELECT_ACK = 8'h02,
		BOP_BUS_CONTROL = 8'h04,
		BOP_BUS_ACK = 8'h08,
		BOP_REQUEST = 8'h10,
		BOP_REQUEST_ACK = 8'h20,
		BOP_RESET_PH1 = 8'h40,
		BOP_RESET_PH2 = 8'h80
	} bop_state_t;
	// Slave condition word.
	typedef struct packed {
		logic busy;
		logic ready;
		logic power_on;
		logic [2:0] irq_class;
	} bop_cond_t;
	// Response bus drive: data, per-bit enable, parity and its enable.
	typedef struct packed {
		logic [7:0] data;
		logic [7:0] oe;
		logic par;
		logic par_oe;
	} bop_drive_t;
endpackage : bop_pkg

// ===== design/bop_sync.sv
// Two-flop synchroniser for a vector of pin inputs.
`timescale 1ns/1ns
module bop_sync #(
	parameter int W = 8
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_reg;
	// First stage feeds only the second stage.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= '0;
			q <= '0;
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule : bop_sync

// ===== design/bop_arbiter.sv
// Two-port allegiance arbiter for hold and preempt selection.
`timescale 1ns/1ns
module bop_arbiter (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic a_selected,
	input wire logic a_hold,
	input wire logic a_preempt,
	input wire logic b_hold,
	input wire logic b_preempt,
	input wire logic b_request,
	output logic port_b_wins
);
	logic win_b;
	// Port B wins when A lacks hold and is unselected or B preempts,
	// or A holds without preempt while B sets both bits.
	always_comb begin
		win_b = (!a_hold && (!a_selected || b_preempt)) ||
			(a_hold && !a_preempt && b_hold && b_preempt);
	end
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			port_b_wins <= 1'b0;
		end else if (b_request) begin
			port_b_wins <= win_b;
		end
	end
endmodule : bop_arbiter

// ===== design/bop_slave.sv
// Slave-side octet decoder and response bus driver.
`timescale 1ns/1ns
`include "bop_map.svh"
module bop_slave
	import bop_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [7:0] bus_out,
	input wire logic [7:0] state_pins,
	input wire logic [2:0] slave_addr,
	input wire logic [5:0] cond_pins,
	input wire logic [15:0] fac_irq_pins,
	input wire logic shutdown_done,
	input wire logic [7:0] transfer_settings,
	input wire logic sel_latch,
	input wire logic mstat_latch,
	input wire logic xfer_ok,
	input wire logic perr_seen,
	input wire logic bus_ctl_known,
	input wire logic a_selected,
	input wire logic [1:0] a_flags,
	output logic [7:0] resp_data,
	output logic [7:0] resp_oe,
	output logic resp_par,
	output logic resp_par_oe,
	output logic skip_transfer,
	output logic port_b_wins,
	output logic port_hold_flag,
	output logic port_preempt_flag,
	output logic [3:0] reset_type,
	output logic reset_fire,
	output logic [1:0] master_stat
);
	logic [7:0] octet;
	logic [7:0] st_raw;
	bop_state_t st;
	bop_state_t st_prev_reg;
	logic [7:0] rq_reg;
	bop_cond_t cond;
	bop_drive_t drv_next;
	logic [7:0] stat_reg;
	logic skip_next;
	logic hit_poll;
	logic addressed;
	logic [7:0] fac_sel;

	// Bus and state pin inputs pass two flops before any logic reads them.
	bop_sync #(.W(8)) u_sync_bus (
		.mclk(mclk),
		.rst_n(rst_n),
		.d(bus_out),
		.q(octet)
	);
	bop_sync #(.W(8)) u_sync_state (
		.mclk(mclk),
		.rst_n(rst_n),
		.d(state_pins),
		.q(st_raw)
	);

	// Parity over a response octet, odd parity.
	function automatic logic odd_par(input logic [7:0] v);
		odd_par = ~(^v);
	endfunction : odd_par

	// One-hot address bit for this slave.
	function automatic logic [7:0] onehot(input logic [2:0] a);
		onehot = 8'h01 << a;
	endfunction : onehot

	// Decode the synchronised control state; illegal codes read as idle.
	always_comb begin
		unique case (st_raw)
			8'h02: st = BOP_SELECT_ACK;
			8'h04: st = BOP_BUS_CONTROL;
			8'h08: st = BOP_BUS_ACK;
			8'h10: st = BOP_REQUEST;
			8'h20: st = BOP_REQUEST_ACK;
			8'h40: st = BOP_RESET_PH1;
			8'h80: st = BOP_RESET_PH2;
			default: st = BOP_IDLE;
		endcase
	end

	// Condition inputs come from the slave's own logic.
	always_comb begin
		cond.busy = cond_pins[5];
		cond.ready = cond_pins[4];
		cond.power_on = cond_pins[3];
		cond.irq_class = cond_pins[2:0];
	end

	// State history for edge detection of phase entry.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st_prev_reg <= BOP_IDLE;
		end else begin
			st_prev_reg <= st;
		end
	end

	// The request modifier is captured while the request state lasts.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rq_reg <= `BOP_OCTET_ZERO;
		end else if (st == BOP_REQUEST) begin
			rq_reg <= octet;
		end
	end

	// Selection flags for this port and the contention arbiter.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			port_hold_flag <= 1'b0;
			port_preempt_flag <= 1'b0;
		end else if (sel_latch) begin
			port_hold_flag <= octet[`BOP_SEL_HOLD_BIT];
			port_preempt_flag <= octet[`BOP_SEL_PREEMPT_BIT];
		end
	end

	// The arbiter judges the selection octet being latched, not the flags of the last one.
	bop_arbiter u_arb (
		.mclk(mclk),
		.rst_n(rst_n),
		.a_selected(a_selected),
		.a_hold(a_flags[1]),
		.a_preempt(a_flags[0]),
		.b_hold(octet[`BOP_SEL_HOLD_BIT]),
		.b_preempt(octet[`BOP_SEL_PREEMPT_BIT]),
		.b_request(sel_latch),
		.port_b_wins(port_b_wins)
	);

	// Master status octet bits are kept for the slave's logic.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			master_stat <= 2'b00;
		end else if (mstat_latch) begin
			master_stat <= octet[`BOP_STAT_OK_BIT:`BOP_STAT_PERR_BIT];
		end
	end

	// Slave ending status: success and detected parity error.
	always_comb begin
		stat_reg = `BOP_OCTET_ZERO;
		stat_reg[`BOP_STAT_OK_BIT] = xfer_ok;
		stat_reg[`BOP_STAT_PERR_BIT] = perr_seen;
	end

	// Unknown bus control octet: skip the following transfer.
	always_comb begin
		skip_next = skip_transfer;
		if (st == BOP_BUS_CONTROL) begin
			skip_next = !bus_ctl_known;
		end else if (st == BOP_IDLE) begin
			skip_next = 1'b0;
		end
	end
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			skip_transfer <= 1'b0;
		end else begin
			skip_transfer <= skip_next;
		end
	end

	// Broadcast poll: OR of all requested conditions.
	always_comb begin
		hit_poll = (octet[`BOP_RQ_BUSY_BIT] && cond.busy) ||
			(octet[`BOP_RQ_READY_BIT] && cond.ready) ||
			(octet[`BOP_RQ_PWRON_BIT] && cond.power_on) ||
			(octet[`BOP_RQ_PWRFAIL_BIT] && shutdown_done) ||
			|(octet[`BOP_RQ_CLASS_MSB:0] & cond.irq_class);
	end

	// Addressed requests compare bits 6..4 against this slave.
	always_comb begin
		addressed = octet[`BOP_RQ_ADDRESSED_BIT] &&
			(rq_reg[`BOP_RQ_ADDR_MSB:`BOP_RQ_ADDR_LSB] == slave_addr);
		fac_sel = rq_reg[`BOP_RQ_RANGE_BIT] ? fac_irq_pins[15:8] : fac_irq_pins[7:0];
	end

	// Response bus selection by state and request form.
	always_comb begin
		drv_next = '0;
		unique case (st)
			BOP_SELECT_ACK: begin
				drv_next.data = stat_reg;
				drv_next.oe = 8'hff;
				drv_next.par = odd_par(stat_reg);
				drv_next.par_oe = 1'b1;
			end
			BOP_BUS_ACK: begin
				drv_next.data = `BOP_OCTET_ZERO;
				drv_next.oe = 8'hff;
				drv_next.par = odd_par(`BOP_OCTET_ZERO);
				drv_next.par_oe = 1'b1;
			end
			BOP_REQUEST: begin
				if (!octet[`BOP_RQ_ADDRESSED_BIT] && hit_poll) begin
					drv_next.data = onehot(slave_addr);
					drv_next.oe = onehot(slave_addr);
				end
			end
			BOP_REQUEST_ACK: begin
				if (rq_reg[`BOP_RQ_ADDRESSED_BIT] &&
					rq_reg[`BOP_RQ_ADDR_MSB:`BOP_RQ_ADDR_LSB] == slave_addr) begin
					if (rq_reg[`BOP_RQ_LOW_MSB:0] == `BOP_NIBBLE_ZERO) begin
						drv_next.data = transfer_settings;
						drv_next.oe = 8'hff;
						drv_next.par = odd_par(transfer_settings);
						drv_next.par_oe = 1'b1;
					end else if (rq_reg[`BOP_RQ_CLASS_MSB:0] == `BOP_CLASS_ZERO) begin
						drv_next.data = {1'b0, cond.busy, cond.ready, port_hold_flag,
							port_preempt_flag, cond.irq_class};
						drv_next.oe = 8'hff;
						drv_next.par = odd_par(drv_next.data);
						drv_next.par_oe = 1'b1;
					end else begin
						drv_next.data = fac_sel;
						drv_next.oe = fac_sel;
					end
				end
			end
			BOP_RESET_PH1, BOP_RESET_PH2: begin
				drv_next = '0;
			end
			BOP_IDLE, BOP_BUS_CONTROL: begin
				drv_next = '0;
			end
		endcase
	end

	// Registered response bus drivers.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			resp_data <= `BOP_OCTET_ZERO;
			resp_oe <= `BOP_OCTET_ZERO;
			resp_par <= 1'b0;
			resp_par_oe <= 1'b0;
		end else begin
			resp_data <= drv_next.data;
			resp_oe <= drv_next.oe;
			resp_par <= drv_next.par;
			resp_par_oe <= drv_next.par_oe;
		end
	end

	// Reset type latched on entry to phase 1 for this slave.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			reset_type <= `BOP_NIBBLE_ZERO;
			reset_fire <= 1'b0;
		end else begin
			reset_fire <= 1'b0;
			if (st == BOP_RESET_PH1 && st_prev_reg != BOP_RESET_PH1 &&
				rq_reg[`BOP_RQ_ADDR_MSB:`BOP_RQ_ADDR_LSB] == slave_addr) begin
				reset_type <= rq_reg[`BOP_RST_TYPE_MSB:0];
				reset_fire <= 1'b1;
			end
		end
	end

	// Unused variable kept consistent.
	logic unused_addr;
	assign unused_addr = addressed;
endmodule : bop_slave

// ===== sim/bop_host.sv
// Host model that drives the control state and octet pins.
`timescale 1ns/1ns
module bop_host (
	input wire logic mclk,
	input wire logic [7:0] st_req,
	input wire logic [7:0] oct_req,
	output logic [7:0] state_pins,
	output logic [7:0] bus_out
);
	// Holds the octet for as long as a state stands; with no state the bus shows the inverse.
	always_ff @(posedge mclk) begin
		state_pins <= st_req;
		bus_out <= st_req == 8'h00 ? ~oct_req : oct_req;
	end
endmodule : bop_host

// ===== sim/bop_props.sv
// Checker for the bus octet slave ports.
`timescale 1ns/1ns
module bop_props (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [7:0] bus_out,
	input wire logic [7:0] state_pins,
	input wire logic [2:0] slave_addr,
	input wire logic [5:0] cond_pins,
	input wire logic [15:0] fac_irq_pins,
	input wire logic shutdown_done,
	input wire logic [7:0] transfer_settings,
	input wire logic sel_latch,
	input wire logic mstat_latch,
	input wire logic bus_ctl_known,
	input wire logic a_selected,
	input wire logic [1:0] a_flags,
	input wire logic [7:0] resp_data,
	input wire logic [7:0] resp_oe,
	input wire logic resp_par,
	input wire logic resp_par_oe,
	input wire logic skip_transfer,
	input wire logic port_b_wins,
	input wire logic [1:0] master_stat
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	// One state held with steady inputs long enough for the sync and answer latency.
	sequence held(logic [7:0] st);
		(state_pins == st && $stable({bus_out, cond_pins, fac_irq_pins, shutdown_done,
			bus_ctl_known, transfer_settings}))[*4];
	endsequence
	// A request octet followed by the request-ack state.
	sequence req_ack;
		held(8'h10) ##1 held(8'h20);
	endsequence
	// The request addresses this slave; port B wins by the contention table.
	wire own = bus_out[7] && bus_out[6:4] == slave_addr;
	wire b_win = !a_flags[1] && (!a_selected || bus_out[0]) ||
		a_flags == 2'b10 && bus_out[1:0] == 2'b11;
	a_poll_answer: assert property (held(8'h10) ##0 !bus_out[7]
		|-> resp_oe == (|(bus_out[6:0] & {cond_pins[5:4], shutdown_done, cond_pins[3:0]}) ?
		8'h01 << slave_addr : 8'h00)) else $error("poll answer wrong");
	a_poll_release: assert property (held(8'h10) ##0 !bus_out[7]
		|-> !resp_par_oe && (resp_data & resp_oe) == resp_oe) else $error("poll drive wrong");
	a_reset_quiet: assert property ((held(8'h40) or held(8'h80))
		|-> resp_oe == 8'h00 && !resp_par_oe) else $error("reset drove bus");
	a_bus_ack_state_zero: assert property (held(8'h08)
		|-> resp_oe == 8'hff && resp_data == 8'h00 && resp_par_oe && resp_par)
		else $error("bus ack octet wrong");
	a_skip_unknown: assert property (held(8'h04) ##0 !bus_ctl_known |-> skip_transfer)
		else $error("unknown control not skipped");
	a_fac_group: assert property (req_ack ##0 own && bus_out[2:0] != 3'h0
		|-> (resp_data & resp_oe) == (bus_out[3] ? fac_irq_pins[15:8] : fac_irq_pins[7:0]))
		else $error("facility answer wrong");
	a_settings_ret: assert property (req_ack ##0 own && bus_out[3:0] == 4'h0
		|-> resp_data == transfer_settings && resp_oe == 8'hff) else $error("settings wrong");
	a_arb_table: assert property ($stable({bus_out, a_selected, a_flags})[*4] ##0 sel_latch
		|=> port_b_wins == $past(b_win)) else $error("arbitration wrong");
	a_mstat_cap: assert property ($stable(bus_out)[*4] ##0 mstat_latch
		|=> master_stat == $past(bus_out[7:6])) else $error("master status wrong");
endmodule : bop_props
bind bop_slave bop_props u_props (.mclk(mclk), .rst_n(rst_n), .bus_out(bus_out),
	.state_pins(state_pins), .slave_addr(slave_addr), .cond_pins(cond_pins),
	.fac_irq_pins(fac_irq_pins), .shutdown_done(shutdown_done),
	.transfer_settings(transfer_settings), .sel_latch(sel_latch), .mstat_latch(mstat_latch),
	.bus_ctl_known(bus_ctl_known), .a_selected(a_selected), .a_flags(a_flags),
	.resp_data(resp_data), .resp_oe(resp_oe), .resp_par(resp_par), .resp_par_oe(resp_par_oe),
	.skip_transfer(skip_transfer), .port_b_wins(port_b_wins), .master_stat(master_stat));

// ===== sim/tb.sv
// Testbench for the bus octet slave with the host model.
`timescale 1ns/1ns
module tb;
	logic mclk, rst_n, sel_latch, mstat_latch, xfer_ok, perr_seen, bus_ctl_known, a_selected;
	logic shutdown_done, resp_par, resp_par_oe, skip_transfer, port_b_wins;
	logic [7:0] st_req, oct_req, state_pins, bus_out, transfer_settings, resp_data, resp_oe;
	logic [5:0] cond_pins;
	logic [15:0] fac_irq_pins;
	logic [1:0] a_flags, master_stat;
	logic [3:0] reset_type;
	logic [7:0] rq [4] = '{8'hd1, 8'hd9, 8'hd0, 8'hc1};
	logic [7:0] ex [4] = '{8'h5a, 8'ha5, 8'h3c, 8'h00};
	int mismatches, comparisons;
	bop_host host (.mclk(mclk), .st_req(st_req), .oct_req(oct_req), .state_pins(state_pins),
		.bus_out(bus_out));
	bop_slave dut (.mclk(mclk), .rst_n(rst_n), .bus_out(bus_out), .state_pins(state_pins),
		.slave_addr(3'h5), .cond_pins(cond_pins), .fac_irq_pins(fac_irq_pins),
		.shutdown_done(shutdown_done), .transfer_settings(transfer_settings),
		.sel_latch(sel_latch), .mstat_latch(mstat_latch), .xfer_ok(xfer_ok),
		.perr_seen(perr_seen), .bus_ctl_known(bus_ctl_known), .a_selected(a_selected),
		.a_flags(a_flags), .resp_data(resp_data), .resp_oe(resp_oe), .resp_par(resp_par),
		.resp_par_oe(resp_par_oe), .skip_transfer(skip_transfer), .port_b_wins(port_b_wins),
		.port_hold_flag(), .port_preempt_flag(), .reset_type(reset_type), .reset_fire(),
		.master_stat(master_stat));
	// Compares one result and counts it.
	task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// Puts a state and octet on the pins and waits until every slave has answered.
	task go(input logic [7:0] st, input logic [7:0] oct);
		@(posedge mclk);
		st_req <= st;
		oct_req <= oct;
		repeat (6) @(posedge mclk);
		#1;
	endtask : go
	// Pulses the selection or master status strobe for one clock.
	task pulse(input logic sel);
		@(posedge mclk);
		sel_latch <= sel;
		mstat_latch <= !sel;
		@(posedge mclk);
		sel_latch <= 1'b0;
		mstat_latch <= 1'b0;
		@(posedge mclk);
		#1;
	endtask : pulse
	// Prints the verdict and ends the run.
	task wrap_up;
		if (mismatches == 0 && comparisons > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : wrap_up
	// Clock of 10 ns.
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// Cuts a hang short.
	initial begin
		repeat (3000) @(posedge mclk);
		mismatches++;
		wrap_up;
	end
	// Test sequence.
	initial begin
		{rst_n, sel_latch, mstat_latch, bus_ctl_known, a_selected, a_flags} = 7'h00;
		{st_req, oct_req, cond_pins, shutdown_done} = 23'h0;
		{xfer_ok, perr_seen, fac_irq_pins, transfer_settings} = {2'b11, 16'ha55a, 8'h3c};
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		for (int i = 0; i < 14; i++) begin
			@(posedge mclk);
			{cond_pins, shutdown_done} <= i < 7 ? 7'h7f : 7'h00;
			go(8'h10, 8'h01 << (i % 7));
			chk("poll oe", i < 7 ? 8'h20 : 8'h00, resp_oe);
			chk("poll par oe", 1'b0, resp_par_oe);
		end
		@(posedge mclk);
		{cond_pins, shutdown_done} <= 7'h62;
		go(8'h10, 8'h11);
		chk("poll or", 8'h20, resp_oe);
		go(8'h10, 8'h10);
		chk("power fail", 8'h00, resp_oe);
		go(8'h08, 8'h00);
		chk("bus ack", 16'hff00, {resp_oe, resp_data});
		chk("bus ack par", 2'b11, {resp_par_oe, resp_par});
		go(8'h04, 8'h3f);
		chk("skip", 1'b1, skip_transfer);
		bus_ctl_known <= 1'b1;
		go(8'h04, 8'h3f);
		chk("skip known", 1'b0, skip_transfer);
		bus_ctl_known <= 1'b0;
		go(8'h02, 8'h00);
		chk("slave status", 2'b11, resp_data[7:6]);
		for (int k = 0; k < 4; k++) begin
			go(8'h10, rq[k]);
			go(8'h20, rq[k]);
			chk("request ack", ex[k], resp_data & resp_oe);
		end
		go(8'h10, 8'hd8);
		go(8'h20, 8'hd8);
		chk("slave irqs", 5'h19, {resp_data[6:5], resp_data[2:0]});
		go(8'h10, 8'hd6);
		go(8'h40, 8'hd6);
		chk("reset quiet", 8'h00, resp_oe);
		chk("reset type", 4'h6, reset_type);
		go(8'h01, 8'h80);
		pulse(1'b0);
		chk("master status", 2'b10, master_stat);
		for (int i = 0; i < 32; i++) begin
			@(posedge mclk);
			{a_selected, a_flags} <= i[4:2];
			go(8'h01, {6'h00, i[1:0]});
			pulse(1'b1);
			chk("arbitration", !i[3] && (!i[4] || i[0]) || i[3:0] == 4'hb, port_b_wins);
		end
		wrap_up;
	end
endmodule : tb
